// ---- design/wdg_pkg.sv ----
// watchdog with reset-cause flags: shared constants and types
// assumes one 50 MHz system clock and an 8-bit register port
package wdg_pkg;

	// --------------------------------------------------------------
	// register port
	// --------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_ADDR  = 8'h60;
	localparam logic [ADDR_W-1:0] CAUSE_ADDR = 8'h61;
	localparam logic [DATA_W-1:0] READ_IDLE  = 8'h00;

	// --------------------------------------------------------------
	// control register fields
	// --------------------------------------------------------------
	localparam int CTRL_IRQ_FLAG_BIT = 7;
	localparam int CTRL_IRQ_EN_BIT   = 6;
	localparam int CTRL_PS3_BIT      = 5;
	localparam int CTRL_UNLOCK_BIT   = 4;
	localparam int CTRL_RST_EN_BIT   = 3;
	localparam int CTRL_PS_LO_MSB    = 2;
	localparam logic [3:0] PERIOD_RESET    = 4'h0;
	localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;

	// --------------------------------------------------------------
	// reset cause register fields
	// --------------------------------------------------------------
	localparam int CAUSE_W          = 4;
	localparam int CAUSE_WDOG_BIT   = 3;
	localparam int CAUSE_BROWN_BIT  = 2;
	localparam int CAUSE_PIN_BIT    = 1;
	localparam int CAUSE_POWER_BIT  = 0;
	localparam logic [CAUSE_W-1:0] CAUSE_POR_VALUE = 4'h1;
	localparam logic [DATA_W-CAUSE_W-1:0] CAUSE_UNUSED = 4'h0;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_HZ          = 50_000_000;
	localparam int WDOG_OSC_HZ     = 128_000;
	localparam int UNLOCK_CYCLES   = 4;
	localparam logic [1:0] UNLOCK_LAST = 2'(UNLOCK_CYCLES - 1);
	localparam logic [1:0] UNLOCK_DONE = 2'h0;
	localparam int CNT_W           = 21;
	localparam int PERIOD_BASE_DEF = 2048;

	// --------------------------------------------------------------
	// pin synchroniser lanes
	// --------------------------------------------------------------
	localparam int SYNC_W     = 4;
	localparam int SYNC_OSC   = 0;
	localparam int SYNC_FUSE  = 1;
	localparam int SYNC_BROWN = 2;
	localparam int SYNC_PIN   = 3;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 4'h0;

	// --------------------------------------------------------------
	// carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} wdg_bus_req_t;

	typedef struct packed {
		logic       irq_flag;
		logic       irq_en;
		logic       unlock;
		logic       rst_en;
		logic [3:0] period;
	} wdg_ctrl_t;

	localparam wdg_ctrl_t CTRL_RESET = '{
		irq_flag: 1'h0, irq_en: 1'h0, unlock: 1'h0, rst_en: 1'h0, period: PERIOD_RESET};

endpackage

// ---- design/wdg_sync2.sv ----
// watchdog with reset-cause flags: two-stage pin synchroniser
// assumes inputs are asynchronous to clk_in
`timescale 1ns/1ps
module wdg_sync2 import wdg_pkg::*; #(
	parameter int                W       = 1,
	parameter logic [W-1:0]      RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         ce_in,
	// pins
	input  wire logic [W-1:0] async_in,
	// synchronised levels
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] stage1_ff;
	logic [W-1:0] stage2_ff;

	// --------------------------------------------------------------
	// two flops, first one feeds only the second
	// --------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stage1_ff <= RST_VAL;
			stage2_ff <= RST_VAL;
		end else if (ce_in) begin
			stage1_ff <= async_in;
			stage2_ff <= stage1_ff;
		end
	end

	assign sync_out = stage2_ff;

endmodule

// ---- design/wdg_top.sv ----
// watchdog with reset-cause flags: counter, modes, unlock window, registers
// assumes rst_in is power-on reset, sys_reset_in any later system reset
//
// Behaviour
// - watchdog reset sets its cause flag; power-on or written zero clears it
// - brown-out sets its cause flag; power-on or written zero clears it
// - pin reset sets its cause flag; power-on or written zero clears it
// - power-on sets its flag; only a written zero clears it
// - upper four cause bits always read zero
// - time-out in interrupt operation sets the interrupt flag
// - vector execution or written one clears the interrupt flag
// - interrupt request needs flag, enable and global enable together
// - combined mode: vector execution clears enable and flag, leaving reset mode
// - combined mode: unserviced flag at next time-out gives system reset
// - fuse unprogrammed: reset/interrupt enables pick stopped, irq, reset, combined
// - fuse programmed: every time-out resets regardless of enables
// - change unlock clears itself four cycles after being written one
// - clearing reset enable or changing period only while unlocked
// - reset enable reads one while watchdog cause flag is set
// - period codes 0 to 9 double from 2048 oscillator cycles; rest reserved
// - counter counts oscillator cycles; kick restarts it
// - programmed fuse locks reset enable at one, interrupt enable at zero
// - reset-causing time-out gives a one-cycle reset pulse
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module wdg_top import wdg_pkg::*; #(
	parameter int PERIOD_BASE_CYCLES = PERIOD_BASE_DEF
) (
	// clock, reset, enable
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              sys_reset_in,
	input  wire logic              ce_in,
	// register port
	input  wire wdg_bus_req_t      bus_in,
	output logic      [DATA_W-1:0] rdata_out,
	// core side
	input  wire logic              kick_in,
	input  wire logic              gie_in,
	input  wire logic              irq_ack_in,
	output logic                   irq_out,
	// pins and reset logic
	input  wire logic              wdog_osc_in,
	input  wire logic              always_on_fuse_in,
	input  wire logic              brownout_event_in,
	input  wire logic              pin_reset_event_in,
	output logic                   wdog_reset_out
);

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	wdg_ctrl_t          ctrl_ff;
	logic [1:0]         unlock_cnt_ff;
	logic [CAUSE_W-1:0] cause_ff;
	logic [CNT_W-1:0]   cnt_ff;
	logic [CNT_W-1:0]   limit;
	logic [3:0]         ps_eff;
	logic               osc_prev_ff;
	logic               rst_pulse_ff;
	logic [DATA_W-1:0]  rdata_ff;
	logic [SYNC_W-1:0]  pins_sync;
	logic               tick;
	logic               fuse_on;
	logic               eff_rst_en;
	logic               eff_irq_en;
	logic               running;
	logic               timeout;
	logic               to_irq;
	logic               to_reset;
	logic               ctrl_wr;
	logic               cause_wr;
	logic               ctrl_rd;
	logic               cause_rd;
	logic               ctrl_reset;
	logic               por_clr_req;
	logic [DATA_W-1:0]  ctrl_view;

	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	wdg_sync2 #(
		.W       (SYNC_W),
		.RST_VAL (SYNC_RESET)
	) u_sync (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.ce_in    (ce_in),
		.async_in ({pin_reset_event_in, brownout_event_in, always_on_fuse_in, wdog_osc_in}),
		.sync_out (pins_sync)
	);

	// oscillator edge, taken from the synchronised copy only
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			osc_prev_ff <= 1'h0;
		end else if (ce_in) begin
			osc_prev_ff <= pins_sync[SYNC_OSC];
		end
	end

	assign tick = pins_sync[SYNC_OSC] & ~osc_prev_ff;

	// --------------------------------------------------------------
	// mode decode
	// --------------------------------------------------------------
	assign fuse_on    = ~pins_sync[SYNC_FUSE];
	assign eff_rst_en = ctrl_ff.rst_en | cause_ff[CAUSE_WDOG_BIT] | fuse_on;
	assign eff_irq_en = ctrl_ff.irq_en & ~fuse_on;
	assign running    = eff_rst_en | eff_irq_en;

	// reserved codes behave as the longest period
	assign ps_eff = (ctrl_ff.period > PERIOD_MAX_CODE) ? PERIOD_MAX_CODE : ctrl_ff.period;
	assign limit  = CNT_W'(PERIOD_BASE_CYCLES) << ps_eff;

	assign timeout  = ce_in & running & tick & (cnt_ff == limit - 1'h1);
	// combined mode with the flag still pending escalates to reset
	assign to_irq   = timeout & eff_irq_en & ~(eff_rst_en & ctrl_ff.irq_flag);
	assign to_reset = timeout & eff_rst_en & (~eff_irq_en | ctrl_ff.irq_flag);

	assign ctrl_reset = rst_in | sys_reset_in;

	// --------------------------------------------------------------
	// time-out counter
	// --------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (ctrl_reset) begin
			cnt_ff <= '0;
		end else if (ce_in) begin
			if (!running || kick_in || timeout) begin
				cnt_ff <= '0;
			end else if (tick) begin
				cnt_ff <= cnt_ff + 1'h1;
			end
		end
	end

	// --------------------------------------------------------------
	// register decode
	// --------------------------------------------------------------
	always_comb begin
		ctrl_wr  = 1'h0;
		cause_wr = 1'h0;
		ctrl_rd  = 1'h0;
		cause_rd = 1'h0;
		if (bus_in.addr == CTRL_ADDR) begin
			ctrl_wr = bus_in.wr;
			ctrl_rd = bus_in.rd;
		end else if (bus_in.addr == CAUSE_ADDR) begin
			cause_wr = bus_in.wr;
			cause_rd = bus_in.rd;
		end
	end

	assign por_clr_req = ce_in & cause_wr & ~bus_in.wdata[CAUSE_POWER_BIT];

	// --------------------------------------------------------------
	// control register
	// --------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (ctrl_reset) begin
			ctrl_ff <= CTRL_RESET;
		end else if (ce_in) begin
			if (ctrl_wr) begin
				ctrl_ff.irq_en <= bus_in.wdata[CTRL_IRQ_EN_BIT];
				ctrl_ff.unlock <= bus_in.wdata[CTRL_UNLOCK_BIT];
				if (bus_in.wdata[CTRL_RST_EN_BIT]) begin
					ctrl_ff.rst_en <= 1'h1;
				end else if (ctrl_ff.unlock) begin
					ctrl_ff.rst_en <= 1'h0;
				end
				if (ctrl_ff.unlock) begin
					ctrl_ff.period <= {bus_in.wdata[CTRL_PS3_BIT],
						bus_in.wdata[CTRL_PS_LO_MSB:0]};
				end
				if (bus_in.wdata[CTRL_IRQ_FLAG_BIT]) begin
					ctrl_ff.irq_flag <= 1'h0;
				end
			end else if (ctrl_ff.unlock && unlock_cnt_ff == UNLOCK_DONE) begin
				ctrl_ff.unlock <= 1'h0;
			end
			if (irq_ack_in) begin
				ctrl_ff.irq_flag <= 1'h0;
				if (eff_rst_en && eff_irq_en) begin
					ctrl_ff.irq_en <= 1'h0;
				end
			end
			if (cause_ff[CAUSE_WDOG_BIT]) begin
				ctrl_ff.rst_en <= 1'h1;
			end
			if (to_irq) begin
				ctrl_ff.irq_flag <= 1'h1;
			end
		end
	end

	// unlock window length
	always_ff @(posedge clk_in) begin
		if (ctrl_reset) begin
			unlock_cnt_ff <= UNLOCK_DONE;
		end else if (ce_in) begin
			if (ctrl_wr && bus_in.wdata[CTRL_UNLOCK_BIT]) begin
				unlock_cnt_ff <= UNLOCK_LAST;
			end else if (unlock_cnt_ff != UNLOCK_DONE) begin
				unlock_cnt_ff <= unlock_cnt_ff - 1'h1;
			end
		end
	end

	// --------------------------------------------------------------
	// reset cause flags, set wins over written zero
	// --------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cause_ff <= CAUSE_POR_VALUE;
		end else if (ce_in) begin
			if (cause_wr) begin
				cause_ff <= cause_ff & bus_in.wdata[CAUSE_W-1:0];
			end
			if (to_reset) begin
				cause_ff[CAUSE_WDOG_BIT] <= 1'h1;
			end
			if (pins_sync[SYNC_BROWN]) begin
				cause_ff[CAUSE_BROWN_BIT] <= 1'h1;
			end
			if (pins_sync[SYNC_PIN]) begin
				cause_ff[CAUSE_PIN_BIT] <= 1'h1;
			end
		end
	end

	// --------------------------------------------------------------
	// reset pulse
	// --------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (ctrl_reset) begin
			rst_pulse_ff <= 1'h0;
		end else if (ce_in) begin
			rst_pulse_ff <= to_reset;
		end
	end

	assign wdog_reset_out = rst_pulse_ff;

	// --------------------------------------------------------------
	// read data and interrupt request
	// --------------------------------------------------------------
	assign ctrl_view = {ctrl_ff.irq_flag, eff_irq_en, ctrl_ff.period[3], ctrl_ff.unlock,
		eff_rst_en, ctrl_ff.period[CTRL_PS_LO_MSB:0]};

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_ff <= READ_IDLE;
		end else if (ce_in) begin
			if (ctrl_rd) begin
				rdata_ff <= ctrl_view;
			end else if (cause_rd) begin
				rdata_ff <= {CAUSE_UNUSED, cause_ff};
			end else begin
				rdata_ff <= READ_IDLE;
			end
		end
	end

	assign rdata_out = rdata_ff;
	assign irq_out   = ctrl_ff.irq_flag & eff_irq_en & gie_in;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	property p_wdog_flag;
		wdog_reset_out |-> cause_ff[CAUSE_WDOG_BIT];
	endproperty
	a_wdog_flag: assert property (p_wdog_flag) else $error("cause flag missing on reset");

	property p_por_clear;
		$fell(cause_ff[CAUSE_POWER_BIT]) |-> $past(por_clr_req);
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("power-on flag lost");

	property p_upper_zero;
		ce_in && cause_rd |=> rdata_out[DATA_W-1:CAUSE_W] == CAUSE_UNUSED;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("unused cause bits set");

	property p_irq_set;
		timeout && eff_irq_en && !eff_rst_en && !sys_reset_in |=> ctrl_ff.irq_flag;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("time-out flag not set");

	property p_combined_ack;
		irq_ack_in && ce_in && eff_rst_en && eff_irq_en && !timeout && !sys_reset_in
			|=> !ctrl_ff.irq_en && !ctrl_ff.irq_flag;
	endproperty
	a_combined_ack: assert property (p_combined_ack) else $error("ack left irq mode on");

	property p_escalate;
		timeout && ctrl_ff.irq_flag && eff_rst_en && !sys_reset_in |=> wdog_reset_out;
	endproperty
	a_escalate: assert property (p_escalate) else $error("pending irq did not reset");

	property p_fuse_reset;
		timeout && fuse_on && !sys_reset_in |=> wdog_reset_out && !ctrl_ff.irq_flag;
	endproperty
	a_fuse_reset: assert property (p_fuse_reset) else $error("fuse mode did not reset");

	property p_unlock_start;
		$rose(ctrl_ff.unlock) |-> unlock_cnt_ff == UNLOCK_LAST;
	endproperty
	a_unlock_start: assert property (p_unlock_start) else $error("unlock window bad start");

	property p_unlock_end;
		ctrl_ff.unlock && unlock_cnt_ff == UNLOCK_DONE && ce_in && !ctrl_wr |=> !ctrl_ff.unlock;
	endproperty
	a_unlock_end: assert property (p_unlock_end) else $error("unlock window overran");

	property p_period_guard;
		ce_in && ctrl_wr && !ctrl_ff.unlock && !sys_reset_in |=> $stable(ctrl_ff.period);
	endproperty
	a_period_guard: assert property (p_period_guard) else $error("period changed locked");

	property p_rst_en_read;
		ce_in && ctrl_rd && cause_ff[CAUSE_WDOG_BIT] |=> rdata_out[CTRL_RST_EN_BIT];
	endproperty
	a_rst_en_read: assert property (p_rst_en_read) else $error("reset enable not forced");

	property p_pulse_len;
		wdog_reset_out && ce_in |=> !wdog_reset_out;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too long");

	property p_restart;
		timeout |=> cnt_ff == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("counter not restarted");

	c_reset_pulse: cover property (wdog_reset_out);
	c_irq:         cover property (irq_out);
	c_unlock:      cover property ($rose(ctrl_ff.unlock));
	c_escalate:    cover property (ctrl_ff.irq_flag && to_reset);

endmodule

// ---- verif/tb.sv ----
// watchdog with reset-cause flags: self-checking testbench
// assumes wdg_top and wdg_pkg from design/, bench drives oscillator and fuse pins itself
`timescale 1ns/1ps

`define CHK(got, exp, what) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) begin \
			num_errors++; \
			$display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp); \
		end \
	end

module tb import wdg_pkg::*;;

	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam int PB = 4;
	logic              clk_in             = 1'b0;
	logic              rst_in             = 1'b1;
	logic              sys_reset_in       = 1'b0;
	logic              ce_in              = 1'b1;
	wdg_bus_req_t      bus_in             = '0;
	logic [DATA_W-1:0] rdata_out;
	logic              kick_in            = 1'b0;
	logic              gie_in             = 1'b0;
	logic              irq_ack_in         = 1'b0;
	logic              irq_out;
	logic              wdog_osc_in        = 1'b0;
	logic              always_on_fuse_in  = 1'b1;
	logic              brownout_event_in  = 1'b0;
	logic              pin_reset_event_in = 1'b0;
	logic              wdog_reset_out;
	logic              last_rst           = 1'b0;
	int                num_errors         = 0;
	int                n_compared         = 0;
	int                n_rst              = 0;
	int                base;
	logic [3:0]        codes [5]          = '{4'h0, 4'h0, 4'h1, 4'h2, 4'ha};

	always #10 clk_in = ~clk_in;

	wdg_top #(.PERIOD_BASE_CYCLES(PB)) dut (
		.clk_in             (clk_in),
		.rst_in             (rst_in),
		.sys_reset_in       (sys_reset_in),
		.ce_in              (ce_in),
		.bus_in             (bus_in),
		.rdata_out          (rdata_out),
		.kick_in            (kick_in),
		.gie_in             (gie_in),
		.irq_ack_in         (irq_ack_in),
		.irq_out            (irq_out),
		.wdog_osc_in        (wdog_osc_in),
		.always_on_fuse_in  (always_on_fuse_in),
		.brownout_event_in  (brownout_event_in),
		.pin_reset_event_in (pin_reset_event_in),
		.wdog_reset_out     (wdog_reset_out)
	);

	// ------------------------------------------------------------------
	// reset pulse monitor
	// ------------------------------------------------------------------
	always @(posedge clk_in) begin
		if (wdog_reset_out === 1'b1) begin
			`CHK(last_rst, 1'b0, "reset pulse too long")
		end
		last_rst <= (wdog_reset_out === 1'b1);
		n_rst <= n_rst + int'(wdog_reset_out === 1'b1);
	end

	// ------------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		bus_in <= '0;
		@(posedge clk_in);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		bus_in <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		bus_in <= '0;
		#1;
		`CHK(rdata_out, e, "read data")
		@(posedge clk_in);
	endtask

	task automatic unlock_wr(input logic [DATA_W-1:0] d);
		wr(CTRL_ADDR, 8'h18);
		wr(CTRL_ADDR, d);
	endtask

	task automatic ticks(input int n);
		for (int i = 0; i < n; i++) begin
			wdog_osc_in <= 1'b1;
			repeat (3) @(posedge clk_in);
			wdog_osc_in <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
		repeat (3) @(posedge clk_in);
	endtask

	task automatic ack();
		irq_ack_in <= 1'b1;
		@(posedge clk_in);
		irq_ack_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic kick();
		kick_in <= 1'b1;
		@(posedge clk_in);
		kick_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic complete_run();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// hang guard
	// ------------------------------------------------------------------
	initial begin
		repeat (100000) @(posedge clk_in);
		num_errors++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd(CAUSE_ADDR, 8'h01);
		rd(CTRL_ADDR, 8'h00);
		// unlock window edge: reads two to five cycles after the write
		for (int k = 0; k < 4; k++) begin
			wr(CTRL_ADDR, 8'h18);
			repeat (k) @(posedge clk_in);
			rd(CTRL_ADDR, (k < 3) ? 8'h18 : 8'h08);
		end
		wr(CTRL_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h08);
		wr(CTRL_ADDR, 8'h0d);
		rd(CTRL_ADDR, 8'h08);
		unlock_wr(8'h40);
		rd(CTRL_ADDR, 8'h40);
		// interrupt mode
		ticks(3);
		rd(CTRL_ADDR, 8'h40);
		ticks(1);
		rd(CTRL_ADDR, 8'hc0);
		`CHK(irq_out, 1'b0, "irq without global enable")
		gie_in <= 1'b1;
		@(posedge clk_in);
		#1;
		`CHK(irq_out, 1'b1, "irq request")
		@(posedge clk_in);
		wr(CTRL_ADDR, 8'hc0);
		rd(CTRL_ADDR, 8'h40);
		`CHK(irq_out, 1'b0, "irq after flag clear")
		ticks(4);
		ack();
		rd(CTRL_ADDR, 8'h40);
		`CHK(n_rst, 0, "reset in irq mode")
		// stopped mode
		wr(CTRL_ADDR, 8'h00);
		ticks(8);
		rd(CTRL_ADDR, 8'h00);
		`CHK(n_rst, 0, "reset in stopped mode")
		// combined mode
		wr(CTRL_ADDR, 8'h48);
		ticks(4);
		rd(CTRL_ADDR, 8'hc8);
		`CHK(n_rst, 0, "reset on first combined time-out")
		ack();
		rd(CTRL_ADDR, 8'h08);
		ticks(4);
		`CHK(n_rst, 1, "reset after serviced irq")
		rd(CAUSE_ADDR, 8'h09);
		wr(CTRL_ADDR, 8'h48);
		ticks(4);
		`CHK(n_rst, 1, "early reset")
		ticks(4);
		`CHK(n_rst, 2, "reset on unserviced irq")
		// system reset keeps flags, forced reset enable
		sys_reset_in <= 1'b1;
		@(posedge clk_in);
		sys_reset_in <= 1'b0;
		@(posedge clk_in);
		rd(CTRL_ADDR, 8'h08);
		wr(CAUSE_ADDR, 8'h00);
		rd(CAUSE_ADDR, 8'h00);
		rd(CTRL_ADDR, 8'h08);
		// start-up clean-up, reset enable cleared through the window
		unlock_wr(8'h00);
		rd(CTRL_ADDR, 8'h00);
		// kick restarts the count, low enable freezes it
		wr(CTRL_ADDR, 8'h08);
		ticks(3);
		kick();
		ce_in <= 1'b0;
		ticks(4);
		ce_in <= 1'b1;
		ticks(3);
		`CHK(n_rst, 2, "reset despite kick or frozen enable")
		ticks(1);
		`CHK(n_rst, 3, "reset after kick period")
		// period codes, each started by a kick; reserved code a runs as code 9
		foreach (codes[i]) begin
			kick();
			unlock_wr({2'b00, codes[i][3], 2'b01, codes[i][2:0]});
			base = n_rst;
			ticks((PB << ((codes[i] > 4'h9) ? 9 : codes[i])) - 1);
			`CHK(n_rst, base, "early time-out")
			ticks(1);
			`CHK(n_rst, base + 1, "time-out length")
		end
		// brown-out and pin causes, power-on clears
		wr(CAUSE_ADDR, 8'h00);
		brownout_event_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		brownout_event_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd(CAUSE_ADDR, 8'h04);
		pin_reset_event_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		pin_reset_event_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd(CAUSE_ADDR, 8'h06);
		wr(CAUSE_ADDR, 8'hff);
		rd(CAUSE_ADDR, 8'h06);
		rst_in <= 1'b1;
		@(posedge clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd(CAUSE_ADDR, 8'h01);
		// programmed fuse
		always_on_fuse_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		wr(CTRL_ADDR, 8'h40);
		rd(CTRL_ADDR, 8'h08);
		base = n_rst;
		ticks(4);
		`CHK(n_rst, base + 1, "fuse forces reset")
		rd(CTRL_ADDR, 8'h08);
		complete_run();
	end

endmodule
